/* File: common/cbd_map.svh */
/*
  Decoder constants: ids, limits, word offsets, register map.
  Assumes 16-bit two's complement block words.
*/
// Function
// RL1: Event id is port base plus slave
// RL2: Event carries five words; spare words ignored
// RL3: Host sends function codes 1-6, 15, 16
// RL4: Swap code applied only with function 3
// RL5: Event builds command into port queue
// RL6: Event reply echoes id, result, id
// RL7: Event fails only when queue holds 100
// RL8: Queue served before regular list entries
// RL9: Regular list runs only enabled entries
// RL10: Disabled entries runnable through control blocks
// RL11: Ids 5001-5006/5101-5106 give port, count
// RL12: Host indexes lie in 0 to 99
// RL13: Control reply echoes id, added count
// RL14: Id -9000 triggers configuration read-back blocks
// RL15: General read-back block word layout
// RL16: List read-back blocks, ids and layout
// RL17: Host handles every read-back block
// RL18: Id 9998 triggers software restart
// RL19: Host sends restart after configuration change
// RL20: Id 9999 triggers full hardware reset
// RL21: Unknown ids ignored, no reply
`ifndef CBD_MAP_SVH
`define CBD_MAP_SVH

// ----------------------------------------
// Block identifiers
// ----------------------------------------
`define CBD_EVT_P1_LO 16'h03e8
`define CBD_EVT_P1_HI 16'h04e7
`define CBD_EVT_P2_LO 16'h07d0
`define CBD_EVT_P2_HI 16'h08cf
`define CBD_CTL_P1_BASE 16'h1388
`define CBD_CTL_P2_BASE 16'h13ec
`define CBD_CTL_MAX 16'h0006
`define CBD_CFG_ID 16'hdcd8
`define CBD_LIST_P1_ID 16'he890
`define CBD_LIST_P2_ID 16'he82c
`define CBD_WARM_ID 16'h270e
`define CBD_COLD_ID 16'h270f

// ----------------------------------------
// Block layout and limits
// ----------------------------------------
`define CBD_HOLD_WORDS 7
`define CBD_W_ID 8'h01
`define CBD_W_RESULT 8'h02
`define CBD_W_CFG_FIRST 8'h02
`define CBD_W_GEN_LAST 8'h3f
`define CBD_W_LIST_LAST 8'hc9
`define CBD_W_TAIL 8'hf9
`define CBD_LAST_BLK 4'h8
`define CBD_QUEUE_DEPTH 7'h64
`define CBD_FC_SWAP 16'h0003

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define CBD_REG_CTRL 8'h00
`define CBD_REG_STATUS 8'h04
`define CBD_REG_QLEVEL 8'h08
`define CBD_REG_LIST_LEN 8'h0c
`define CBD_REG_COUNTS 8'h10
`define CBD_REG_EN_BASE 3'h1
`define CBD_CTRL_RST 1'b1
`define CBD_LIST_LEN_RST 7'h64
`define CBD_EN_RST {4{32'hffffffff}}
`define CBD_RESP_OKAY 2'h0
`define CBD_RESP_SLVERR 2'h2

`endif

/* File: common/cbd_pkg.sv */
/*
  Types of the decoder and its port scheduler.
  Assumes cbd_map.svh alongside.
*/
package cbd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CTRL = 2'b01,
    ST_RESP = 2'b11
  } state_t;

  typedef struct packed {
    logic from_list;
    logic [6:0] list_index;
    logic [7:0] slave;
    logic [15:0] db_addr;
    logic [15:0] point_count;
    logic [15:0] swap;
    logic [15:0] func;
    logic [15:0] remote;
  } qentry_t;

  typedef struct packed {
    qentry_t [99:0] mem;
    logic [6:0] head;
    logic [6:0] tail;
    logic [6:0] level;
    logic [6:0] list_ptr;
    logic [6:0] scan_cnt;
    logic scanning;
    logic exec_valid;
    logic exec_queued;
    logic exec_idle;
    qentry_t exec_entry;
  } sched_t;

  typedef struct packed {
    state_t st;
    logic [6:0][15:0] wb;
    logic [15:0] rid;
    logic [15:0] result;
    logic port;
    logic [2:0] ctrl_n;
    logic [2:0] ctrl_k;
    logic cfg_mode;
    logic [3:0] blk;
    logic [7:0] widx;
    logic pend;
    logic wr_ready;
    logic out_valid;
    logic [7:0] out_index;
    logic [15:0] out_data;
    logic cfg_rd_en;
    logic [11:0] cfg_addr;
    logic warm;
    logic cold;
    logic [1:0] push;
    qentry_t push_entry;
    logic [15:0] ev_ok;
    logic [15:0] ev_fail;
    logic enable;
    logic [1:0][6:0] list_len;
    logic [1:0][127:0] en;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_t;

endpackage : cbd_pkg

/* File: verilog/cbd_port_sched.sv */
/*
  Per-port 100-entry command queue and list walker.
  Assumes no push when full and one exec_req outstanding.
*/
`include "cbd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cbd_port_sched (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Queue fill side
  input wire logic flush,
  input wire logic push,
  input wire cbd_pkg::qentry_t push_entry,
  output logic [6:0] level,
  // List setup
  input wire logic [6:0] list_len,
  input wire logic [99:0] en_map,
  // Engine side
  input wire logic exec_req,
  output logic exec_valid,
  output logic exec_queued,
  output logic exec_idle,
  output cbd_pkg::qentry_t exec_entry
);

  cbd_pkg::sched_t s;
  cbd_pkg::sched_t next_s;
  logic pop;

  always_comb
  begin
    next_s = s;
    pop = 1'b0;
    next_s.exec_valid = 1'b0;
    next_s.exec_idle = 1'b0;
    if (exec_req || s.scanning)
    begin
      if (s.level != 7'h00)
      begin
        // Queue beats the list
        pop = 1'b1; // RL8
        next_s.scanning = 1'b0;
        next_s.exec_valid = 1'b1;
        next_s.exec_queued = 1'b1;
        next_s.exec_entry = s.mem[s.head];
      end
      else if (exec_req)
      begin
        next_s.scanning = 1'b1;
        next_s.scan_cnt = 7'h00;
      end
      else if (list_len == 7'h00 || s.scan_cnt >= list_len)
      begin
        // Nothing enabled
        next_s.scanning = 1'b0;
        next_s.exec_valid = 1'b1;
        next_s.exec_idle = 1'b1;
      end
      else
      begin
        next_s.list_ptr = (s.list_ptr + 7'h01 >= list_len) ? 7'h00 : s.list_ptr + 7'h01;
        next_s.scan_cnt = s.scan_cnt + 7'h01;
        if (s.list_ptr < list_len && en_map[s.list_ptr])
        begin
          next_s.scanning = 1'b0; // RL9
          next_s.exec_valid = 1'b1;
          next_s.exec_queued = 1'b0;
          next_s.exec_entry = '0;
          next_s.exec_entry.from_list = 1'b1;
          next_s.exec_entry.list_index = s.list_ptr;
        end
      end
    end
    if (pop)
    begin
      next_s.head = (s.head == `CBD_QUEUE_DEPTH - 7'h01) ? 7'h00 : s.head + 7'h01;
    end
    if (push)
    begin
      next_s.mem[s.tail] = push_entry; // RL5
      next_s.tail = (s.tail == `CBD_QUEUE_DEPTH - 7'h01) ? 7'h00 : s.tail + 7'h01;
    end
    next_s.level = s.level + {6'h00, push} - {6'h00, pop};
    if (flush)
    begin
      next_s.head = 7'h00;
      next_s.tail = 7'h00;
      next_s.level = 7'h00;
      next_s.list_ptr = 7'h00;
      next_s.scanning = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign exec_valid = s.exec_valid;
  assign exec_queued = s.exec_queued;
  assign exec_idle = s.exec_idle;
  assign exec_entry = s.exec_entry;

endmodule : cbd_port_sched

`default_nettype wire

/* File: verilog/cbd_decoder.sv */
/*
  Backplane command block decoder: takes write blocks word by word,
  acts on event, command control, read-back and restart blocks, and
  streams answer blocks. Registers sit behind an AXI4-Lite slave.
  Assumes write and read block streams, the configuration store and the
  protocol engines all run on aclk; none of them need synchronising.
*/
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`include "cbd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cbd_decoder (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Write block stream from host
  input wire logic wr_valid,
  input wire logic [7:0] wr_index,
  input wire logic [15:0] wr_data,
  input wire logic wr_last,
  output logic wr_ready,
  // Read block stream to host
  output logic rd_valid,
  output logic [7:0] rd_index,
  output logic [15:0] rd_data,
  input wire logic rd_ready,
  // Configuration store
  output logic cfg_rd_en,
  output logic [11:0] cfg_addr,
  input wire logic [15:0] cfg_rd_data,
  // Protocol engines, one lane per port
  input wire logic [1:0] exec_req,
  output logic [1:0] exec_valid,
  output logic [1:0] exec_queued,
  output logic [1:0] exec_idle,
  output logic [1:0][6:0] exec_list_index,
  output logic [1:0][7:0] exec_slave,
  output logic [1:0][15:0] exec_db_addr,
  output logic [1:0][15:0] exec_point_count,
  output logic [1:0][15:0] exec_swap,
  output logic [1:0][15:0] exec_func,
  output logic [1:0][15:0] exec_remote,
  // Restarts
  output logic warm_restart,
  output logic cold_reset
);

  cbd_pkg::top_t s;
  cbd_pkg::top_t next_s;
  logic [1:0][6:0] level;
  cbd_pkg::qentry_t [1:0] entry;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // Per-port queues and schedulers
  // ----------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    cbd_port_sched u_sched (
      .aclk(aclk),
      .aresetn(aresetn),
      .flush(s.warm || s.cold),
      .push(s.push[p]),
      .push_entry(s.push_entry),
      .level(level[p]),
      .list_len(s.list_len[p]),
      .en_map(s.en[p][99:0]),
      .exec_req(exec_req[p]),
      .exec_valid(exec_valid[p]),
      .exec_queued(exec_queued[p]),
      .exec_idle(exec_idle[p]),
      .exec_entry(entry[p])
    );
    assign exec_list_index[p] = entry[p].list_index;
    assign exec_slave[p] = entry[p].slave;
    assign exec_db_addr[p] = entry[p].db_addr;
    assign exec_point_count[p] = entry[p].point_count;
    assign exec_swap[p] = entry[p].swap;
    assign exec_func[p] = entry[p].func;
    assign exec_remote[p] = entry[p].remote;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [6:0][15:0] w;
    logic [15:0] id;
    logic [15:0] idx;
    logic [15:0] blk_id;
    logic [7:0] last_cfg;
    logic [7:0] eff;
    logic fetch;
    logic take;
    w = s.wb;
    id = 16'h0000;
    idx = 16'h0000;
    blk_id = 16'h0000;
    last_cfg = 8'h00;
    eff = 8'h00;
    fetch = 1'b0;
    take = 1'b0;
    next_s = s;
    next_s.push = 2'b00;
    next_s.warm = 1'b0;
    next_s.cold = 1'b0;
    next_s.cfg_rd_en = 1'b0;
    if (s.out_valid && rd_ready)
    begin
      next_s.out_valid = 1'b0;
    end
    // Count the push still in flight
    eff = {1'b0, level[s.port]} + {7'h00, s.push[s.port]};

    unique case (s.st)
      cbd_pkg::ST_IDLE:
      begin
        if (wr_valid && s.wr_ready)
        begin
          // Spare words dropped
          if (wr_index < 8'(`CBD_HOLD_WORDS))
          begin
            w[wr_index[2:0]] = wr_data; // RL2
          end
          next_s.wb = w;
          id = w[0];
          if (wr_last && s.enable)
          begin
            next_s.rid = id;
            next_s.widx = 8'h00;
            next_s.cfg_mode = 1'b0;
            next_s.result = 16'h0000;
            if ((id >= `CBD_EVT_P1_LO && id <= `CBD_EVT_P1_HI) || (id >= `CBD_EVT_P2_LO && id <= `CBD_EVT_P2_HI))
            begin
              next_s.port = (id >= `CBD_EVT_P2_LO); // RL1
              eff = {1'b0, level[next_s.port]};
              next_s.push_entry = '0;
              next_s.push_entry.slave = 8'(id - (next_s.port ? `CBD_EVT_P2_LO : `CBD_EVT_P1_LO)); // RL1
              next_s.push_entry.db_addr = w[1];
              next_s.push_entry.point_count = w[2];
              next_s.push_entry.swap = (w[4] == `CBD_FC_SWAP) ? w[3] : 16'h0000; // RL4
              next_s.push_entry.func = w[4];
              next_s.push_entry.remote = w[5];
              if (eff < {1'b0, `CBD_QUEUE_DEPTH})
              begin
                next_s.push[next_s.port] = 1'b1; // RL5
                next_s.result = 16'h0001; // RL6
                next_s.ev_ok = s.ev_ok + 16'h0001;
              end
              else
              begin
                next_s.ev_fail = s.ev_fail + 16'h0001; // RL7
              end
              next_s.st = cbd_pkg::ST_RESP;
            end
            else if ((id > `CBD_CTL_P1_BASE && id <= `CBD_CTL_P1_BASE + `CBD_CTL_MAX) ||
                     (id > `CBD_CTL_P2_BASE && id <= `CBD_CTL_P2_BASE + `CBD_CTL_MAX))
            begin
              next_s.port = (id > `CBD_CTL_P2_BASE); // RL11
              next_s.ctrl_n = 3'(id - (next_s.port ? `CBD_CTL_P2_BASE : `CBD_CTL_P1_BASE)); // RL11
              next_s.ctrl_k = 3'h0;
              next_s.st = cbd_pkg::ST_CTRL;
            end
            else if (id == `CBD_CFG_ID)
            begin
              next_s.cfg_mode = 1'b1; // RL14
              next_s.blk = 4'h0;
              next_s.pend = 1'b0;
              next_s.st = cbd_pkg::ST_RESP;
            end
            else if (id == `CBD_WARM_ID)
            begin
              next_s.warm = 1'b1; // RL18
            end
            else if (id == `CBD_COLD_ID)
            begin
              next_s.cold = 1'b1; // RL20
            end
            // Other ids: no action, no answer; RL21
          end
        end
      end

      cbd_pkg::ST_CTRL:
      begin
        if (s.ctrl_k == s.ctrl_n)
        begin
          next_s.st = cbd_pkg::ST_RESP;
        end
        else
        begin
          idx = s.wb[s.ctrl_k + 3'h1];
          // Undefined indexes skipped, not counted
          if (idx < {9'h000, s.list_len[s.port]} && eff < {1'b0, `CBD_QUEUE_DEPTH})
          begin
            next_s.push_entry = '0;
            next_s.push_entry.from_list = 1'b1;
            next_s.push_entry.list_index = idx[6:0]; // RL10
            next_s.push[s.port] = 1'b1;
            next_s.result = s.result + 16'h0001; // RL13
          end
          next_s.ctrl_k = s.ctrl_k + 3'h1;
        end
      end

      cbd_pkg::ST_RESP:
      begin
        if (s.cfg_mode)
        begin
          if (s.blk == 4'h0)
          begin
            blk_id = `CBD_CFG_ID; // RL15
            last_cfg = `CBD_W_GEN_LAST;
          end
          else if (s.blk <= 4'h4)
          begin
            blk_id = `CBD_LIST_P1_ID - {12'h000, s.blk - 4'h1}; // RL16
            last_cfg = `CBD_W_LIST_LAST;
          end
          else
          begin
            blk_id = `CBD_LIST_P2_ID - {12'h000, s.blk - 4'h5}; // RL16
            last_cfg = `CBD_W_LIST_LAST;
          end
          fetch = (s.widx >= `CBD_W_CFG_FIRST) && (s.widx <= last_cfg);
        end
        else
        begin
          blk_id = s.rid;
        end
        if (!s.out_valid || rd_ready)
        begin
          if (fetch && !s.pend)
          begin
            // Store answers in the same cycle that its address stands on cfg_addr
            next_s.cfg_rd_en = 1'b1;
            next_s.cfg_addr = {s.blk, s.widx};
            next_s.pend = 1'b1;
          end
          else
          begin
            take = 1'b1;
            next_s.pend = 1'b0;
            next_s.out_valid = 1'b1;
            next_s.out_index = s.widx;
            if (fetch)
            begin
              next_s.out_data = cfg_rd_data;
            end
            else if (s.widx == `CBD_W_ID || s.widx == `CBD_W_TAIL)
            begin
              next_s.out_data = blk_id; // RL6 RL13
            end
            else if (s.widx == `CBD_W_RESULT && !s.cfg_mode)
            begin
              next_s.out_data = s.result;
            end
            else
            begin
              next_s.out_data = 16'h0000;
            end
          end
        end
        if (take)
        begin
          next_s.widx = s.widx + 8'h01;
          if (s.widx == `CBD_W_TAIL)
          begin
            next_s.widx = 8'h00;
            if (s.cfg_mode && s.blk != `CBD_LAST_BLK)
            begin
              next_s.blk = s.blk + 4'h1;
            end
            else
            begin
              next_s.st = cbd_pkg::ST_IDLE;
            end
          end
        end
      end

      default:
      begin
        next_s.st = cbd_pkg::ST_IDLE;
      end
    endcase
    next_s.wr_ready = (next_s.st == cbd_pkg::ST_IDLE);

    // ----------------------------------------
    // AXI4-Lite register slave
    // ----------------------------------------
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `CBD_RESP_OKAY;
      if (s.awaddr == `CBD_REG_CTRL)
      begin
        next_s.enable = s.wstrb[0] ? s.wdata[0] : s.enable;
      end
      else if (s.awaddr == `CBD_REG_LIST_LEN)
      begin
        // Clamp to a full list
        for (int p = 0; p < 2; p++)
        begin
          if (s.wstrb[p*2])
          begin
            next_s.list_len[p] = (s.wdata[p*16 +: 7] > `CBD_QUEUE_DEPTH) ? `CBD_QUEUE_DEPTH : s.wdata[p*16 +: 7];
          end
        end
      end
      else if (s.awaddr[7:5] == `CBD_REG_EN_BASE && s.awaddr[1:0] == 2'h0)
      begin
        next_s.en[s.awaddr[4]][s.awaddr[3:2]*32 +: 32] =
          merge(s.en[s.awaddr[4]][s.awaddr[3:2]*32 +: 32], s.wdata, s.wstrb);
      end
      else if (s.awaddr != `CBD_REG_STATUS && s.awaddr != `CBD_REG_QLEVEL && s.awaddr != `CBD_REG_COUNTS)
      begin
        next_s.bresp = `CBD_RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `CBD_RESP_OKAY;
      next_s.rdata = 32'h00000000;
      if (s_axi_araddr == `CBD_REG_CTRL)
      begin
        next_s.rdata = {31'h0, s.enable};
      end
      else if (s_axi_araddr == `CBD_REG_STATUS)
      begin
        next_s.rdata = {24'h0, s.blk, s.out_valid, s.cfg_mode, s.st};
      end
      else if (s_axi_araddr == `CBD_REG_QLEVEL)
      begin
        next_s.rdata = {9'h0, level[1], 9'h0, level[0]};
      end
      else if (s_axi_araddr == `CBD_REG_LIST_LEN)
      begin
        next_s.rdata = {9'h0, s.list_len[1], 9'h0, s.list_len[0]};
      end
      else if (s_axi_araddr == `CBD_REG_COUNTS)
      begin
        next_s.rdata = {s.ev_fail, s.ev_ok};
      end
      else if (s_axi_araddr[7:5] == `CBD_REG_EN_BASE && s_axi_araddr[1:0] == 2'h0)
      begin
        next_s.rdata = s.en[s_axi_araddr[4]][s_axi_araddr[3:2]*32 +: 32];
      end
      else
      begin
        next_s.rresp = `CBD_RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.enable <= `CBD_CTRL_RST;
      s.list_len <= {`CBD_LIST_LEN_RST, `CBD_LIST_LEN_RST};
      s.en <= {`CBD_EN_RST, `CBD_EN_RST};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign wr_ready = s.wr_ready;
  assign rd_valid = s.out_valid;
  assign rd_index = s.out_index;
  assign rd_data = s.out_data;
  assign cfg_rd_en = s.cfg_rd_en;
  assign cfg_addr = s.cfg_addr;
  assign warm_restart = s.warm;
  assign cold_reset = s.cold;

endmodule : cbd_decoder

`default_nettype wire

/* File: dv/cbd_decoder_monitor.sv */
/* Port checker for cbd_decoder.
   Assumes one clock domain, bound below. */
`timescale 1ns/1ps
`default_nettype none
module cbd_decoder_monitor (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [15:0] rd_data,
  input wire logic [1:0] exec_valid,
  input wire logic [1:0][15:0] exec_swap,
  input wire logic [1:0][15:0] exec_func,
  input wire logic warm_restart,
  input wire logic cold_reset
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ans_start;
    $rose(rd_valid);
  endsequence
  sequence rd_stall;
    rd_valid && !rd_ready;
  endsequence
  chk_busy_after_end: assert property (ans_start |-> !wr_ready) else $error("busy");
  chk_rd_hold: assert property (rd_stall |=> rd_valid && $stable(rd_data)) else $error("rd");
  chk_swap_port1: assert property (exec_valid[0] |-> exec_func[0] == 16'h0003 || exec_swap[0] == 16'h0000)
    else $error("swap");
  chk_swap_port2: assert property (exec_valid[1] |-> exec_func[1] == 16'h0003 || exec_swap[1] == 16'h0000)
    else $error("swap");
  chk_warm_pulse: assert property (warm_restart |=> !warm_restart) else $error("warm");
  chk_cold_pulse: assert property (cold_reset |=> !cold_reset) else $error("cold");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r");
endmodule : cbd_decoder_monitor
bind cbd_decoder cbd_decoder_monitor mon (.*);
`default_nettype wire

/* File: dv/cbd_host_model.sv */
/* Host model: sends write blocks, takes answers, serves the store.
   Assumes one clock. */
`timescale 1ns/1ps
`default_nettype none
module cbd_host_model (
  // Clock and pacing
  input wire logic aclk,
  input wire logic slow,
  // Block streams and store
  output logic wr_valid,
  output logic [7:0] wr_index,
  output logic [15:0] wr_data,
  output logic wr_last,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_index,
  input wire logic [15:0] rd_data,
  output logic rd_ready,
  input wire logic cfg_rd_en,
  input wire logic [11:0] cfg_addr,
  output logic [15:0] cfg_rd_data
);
  logic [15:0] mem [0:249];
  int nblk = 0;
  initial {wr_valid, wr_index, wr_data, wr_last, rd_ready} = '0;
  // Store reads as its address while the address stands
  assign cfg_rd_data = {4'h0, cfg_addr};
  always @(posedge aclk)
  begin
    rd_ready <= slow ? ~rd_ready : 1'b1;
    if (rd_valid && rd_ready)
    begin
      mem[rd_index] <= rd_data;
      nblk <= nblk + (rd_index == 8'hf9);
    end
  end
  task send(input logic [15:0] id, input logic [79:0] p);
    @(posedge aclk);
    for (int i = 0; i < 6; i++)
    begin
      wr_valid <= 1'b1;
      wr_index <= 8'(i);
      wr_data <= i == 0 ? id : p[16 * (5 - i) +: 16];
      wr_last <= i == 5;
      @(negedge aclk);
      while (!wr_ready)
        @(negedge aclk);
      @(posedge aclk);
    end
    wr_valid <= 1'b0;
    wr_last <= 1'b0;
    // Idle lines show the inverse
    wr_data <= ~wr_data;
  endtask : send
endmodule : cbd_host_model
`default_nettype wire

/* File: dv/cbd_decoder_tb.sv */
/* Decoder bench with host model.
   Assumes the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module cbd_decoder_tb;
  logic aclk, aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic wr_valid, wr_last, wr_ready, rd_valid, rd_ready, cfg_rd_en, warm_restart, cold_reset;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, wr_index, rd_index;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [15:0] wr_data, rd_data, cfg_rd_data;
  logic [11:0] cfg_addr;
  logic [1:0] exec_req, s_axi_bresp, s_axi_rresp, exec_valid, exec_queued, exec_idle;
  logic [1:0][6:0] exec_list_index;
  logic [1:0][7:0] exec_slave;
  logic [1:0][15:0] exec_db_addr, exec_point_count, exec_swap, exec_func, exec_remote;
  int error_cnt = 0, total_checks = 0, nw = 0, nc = 0;
  cbd_decoder dut (.*);
  cbd_host_model host (.*);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    nw <= nw + warm_restart;
    nc <= nc + cold_reset;
  end
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= {a, d, a};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wstrb} <= {wr, wr, wr, {4{wr}}};
    {s_axi_arvalid, s_axi_rready} <= {!wr, !wr};
    @(negedge aclk);
    while (wr ? !(s_axi_awready && s_axi_wready) : !s_axi_arready)
      @(negedge aclk);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    @(negedge aclk);
    while (wr ? !s_axi_bvalid : !s_axi_rvalid)
      @(negedge aclk);
    chk(wr ? s_axi_bresp === r : s_axi_rdata === d && s_axi_rresp === r, "axi");
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : axi
  task blk(input logic [15:0] id, input logic [79:0] p, input int n, input logic [15:0] res);
    int b;
    b = host.nblk;
    host.send(id, p);
    while (host.nblk != b + n)
      @(posedge aclk);
    if (n == 1)
      chk(host.mem[1] === id && host.mem[2] === res && host.mem[249] === id, "reply");
  endtask : blk
  task ex(input int p, input int k, input logic [6:0] li, input logic [7:0] sl, input logic [15:0] sw);
    exec_req[p] <= 1'b1;
    @(posedge aclk);
    exec_req[p] <= 1'b0;
    @(negedge aclk);
    while (!exec_valid[p])
      @(negedge aclk);
    chk(exec_queued[p] === (k != 2) && (k == 0 ? exec_slave[p] === sl && exec_swap[p] === sw
      : exec_list_index[p] === li), "exec");
    @(posedge aclk);
  endtask : ex
  task t_evt();
    axi(1'b0, 8'h00, 32'h1, 2'h0);
    axi(1'b0, 8'h40, 32'h0, 2'h2);
    blk(16'h03ed, {16'h0010, 16'h0004, 16'h0002, 16'h0003, 16'h0100}, 1, 16'h0001);
    blk(16'h07d9, {16'h0020, 16'h0001, 16'h0007, 16'h0004, 16'h0200}, 1, 16'h0001);
    blk(16'h13ee, {16'h0003, 16'h0004, 48'h0}, 1, 16'h0002);
    ex(0, 0, 7'h0, 8'h05, 16'h0002);
    ex(1, 0, 7'h0, 8'h09, 16'h0000);
    ex(1, 1, 7'h03, 8'h0, 16'h0);
    for (int i = 0; i < 101; i++)
      blk(16'h03e8 + 16'(i), {16'h0001, 16'h0001, 16'h0, 16'h0006, 16'h0}, 1, 16'(i < 100));
    $display("event tests done");
  endtask : t_evt
  task t_misc();
    blk(16'h0bba, 80'h0, 0, 16'h0);
    repeat (50) @(posedge aclk);
    chk(host.nblk === 104, "no reply");
    slow <= 1'b1;
    blk(16'hdcd8, 80'h0, 9, 16'h0);
    slow <= 1'b0;
    chk(host.mem[1] === 16'he829 && host.mem[2] === 16'h0802 && host.mem[201] === 16'h08c9, "list");
    blk(16'h270e, 80'h0, 0, 16'h0);
    blk(16'h270f, 80'h0, 0, 16'h0);
    repeat (4) @(posedge aclk);
    chk(nw === 1 && nc === 1, "restart");
    axi(1'b1, 8'h20, 32'hfffffff0, 2'h0);
    ex(0, 2, 7'h04, 8'h0, 16'h0);
    $display("misc tests done");
  endtask : t_misc
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, exec_req} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_evt();
    t_misc();
    report_and_stop();
  end
  initial
  begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
endmodule : cbd_decoder_tb
`default_nettype wire
